/* inc/dltc_pkg.sv */
/*
  constants, field layout and types of the line-state termination control
  block. assumes a 100 MHz aclk and an 8-bit AXI4-Lite byte address space.
*/
package dltc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SAMPLE_HZ = 8000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int SETTLE_SAMPLES = 1548;
  // filter group delay, already inside the settle figure
  localparam int GROUP_DELAY_SAMPLES = 12;
  localparam int ID_CHECK_SAMPLES = 4;
  localparam int CODE_W = 5;
  localparam int ADDR_W = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_LINK = 6'h06;
  localparam logic [5:0] IDX_DCTERM = 6'h10;
  localparam logic [5:0] IDX_LEVEL = 6'h12;
  localparam logic [5:0] IDX_SENSE = 6'h13;
  localparam int DCT_HOOK = 0;
  localparam int DCT_MON = 1;
  localparam int DCT_SEL = 2;
  localparam int DCT_LIM = 4;
  localparam int DCT_PAR = 5;
  localparam int LVL_FULL = 0;
  localparam int LVL_VOL = 1;
  localparam int LVL_MODE = 2;
  localparam int ST_DOD = 5;
  localparam int ST_VALID = 6;
  localparam int ST_OVL = 7;
  localparam int LNK_PDL = 0;
  localparam int LNK_OK = 1;
  localparam int LNK_FAIL = 2;
  localparam logic [7:0] DCTERM_RST = 8'h08;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_OVL = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    TERM_LV = 2'b00,
    TERM_JAPAN = 2'b01,
    TERM_FCC = 2'b10,
    TERM_CTR21 = 2'b11
  } dltc_term_type;
  // full scale classes: -1, +3.2, -2.71, -5 dBm
  typedef enum logic [2:0] {
    FS_M1 = 3'b000,
    FS_P3_2 = 3'b001,
    FS_M2_71 = 3'b010,
    FS_M5 = 3'b011
  } dltc_fs_type;
  typedef enum logic [1:0] {
    LINK_DOWN = 2'b00,
    LINK_CHECK = 2'b01,
    LINK_UP = 2'b10,
    LINK_FAIL = 2'b11
  } dltc_link_type;
endpackage : dltc_pkg

/* inc/dltc_settle_if.sv */
/*
  carrier between the top and the off-hook settle timer.
  assumes one clock domain, aclk.
*/
`timescale 1ns/1ps
interface dltc_settle_if;
  logic sample_tick;
  logic hook_active;
  logic data_valid;
  modport settle_end (input sample_tick, input hook_active,
    output data_valid);
  modport ctrl_end (output sample_tick, output hook_active,
    input data_valid);
endinterface : dltc_settle_if

/* core/dltc_sync.sv */
/*
  three-stage synchroniser for a bus of pin levels.
  assumes the bus settles between samples; a change is taken once
  stages two and three agree.
*/
`timescale 1ns/1ps
module dltc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1, s2, s3, next_q;
  always_comb
  begin
    next_q = (s2 == s3) ? s3 : q;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule : dltc_sync

/* core/dltc_settle.sv */
/*
  off-hook settle timer counted in sample periods.
  assumes sample_tick is a one-cycle enable from the sample divider.
*/
`timescale 1ns/1ps
module dltc_settle #(
  parameter int SETTLE = dltc_pkg::SETTLE_SAMPLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  dltc_settle_if.settle_end sif
);
  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE);
  logic [CW-1:0] cnt, next_cnt;
  logic next_valid;
  always_comb
  begin
    next_cnt = cnt;
    next_valid = sif.data_valid;
    if (!sif.hook_active)
    begin
      next_cnt = '0;
      next_valid = 1'b0;
    end
    else if (sif.sample_tick && cnt != LAST)
    begin
      next_cnt = cnt + 1'b1;
      next_valid = (cnt + 1'b1) == LAST;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= '0;
      sif.data_valid <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      sif.data_valid <= next_valid;
    end
  end
  property p_settle_done;
    @(posedge aclk) disable iff (!aresetn)
    (sif.hook_active && sif.sample_tick && cnt == LAST - 1'b1)
      |=> sif.data_valid;
  endproperty
  a_settle_done: assert property (p_settle_done)
    else $error("line data not valid after settle count");
  property p_settle_drop;
    @(posedge aclk) disable iff (!aresetn)
    !sif.hook_active |=> !sif.data_valid ##1 !sif.data_valid[*1];
  endproperty
  a_settle_drop: assert property (p_settle_drop)
    else $error("line data valid while on-hook");
endmodule : dltc_settle

/* core/dltc_top.sv */
/*
  line-state and dc termination control: AXI4-Lite registers, isolated link
  enable with line-side identity check, sense code selection, off-hook
  settle timing, termination and level outputs to the line side.
  assumes line-side pins are asynchronous to aclk and change slowly.
*/
`timescale 1ns/1ps
module dltc_top #(
  parameter int SAMPLE_DIV = dltc_pkg::SAMPLE_DIV,
  parameter int SETTLE = dltc_pkg::SETTLE_SAMPLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [4:0] line_voltage_in,
  input wire logic [4:0] loop_current_in,
  input wire logic [4:0] monitor_in,
  input wire logic line_dropout_in,
  input wire logic line_id_match_in,
  output logic link_enable,
  output logic hookswitch_on,
  output dltc_pkg::dltc_term_type dc_term_mode,
  output logic current_limit_on,
  output logic parallel_imped_on,
  output logic reduced_voltage_on,
  output dltc_pkg::dltc_fs_type full_scale_code,
  output logic line_data_valid
);
  localparam int DW = $clog2(SAMPLE_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(SAMPLE_DIV - 1);
  localparam logic [2:0] ID_LAST = 3'(dltc_pkg::ID_CHECK_SAMPLES - 1);

  dltc_settle_if sif ();
  logic [14:0] pins_s;
  logic [1:0] flags_s;
  logic [4:0] volt_s, cur_s, mon_s;

  dltc_sync #(.W(15)) u_sync_code (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({line_voltage_in, loop_current_in, monitor_in}),
    .q(pins_s)
  );
  dltc_sync #(.W(2)) u_sync_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({line_dropout_in, line_id_match_in}),
    .q(flags_s)
  );
  assign volt_s = pins_s[14:10];
  assign cur_s = pins_s[9:5];
  assign mon_s = pins_s[4:0];

  dltc_settle #(.SETTLE(SETTLE)) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif)
  );

  // sample-rate enable
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic tick, next_tick;
  always_comb
  begin
    next_tick = div_cnt == DIV_LAST;
    next_div_cnt = next_tick ? '0 : div_cnt + 1'b1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  // AXI write channel
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [5:0] aw_idx, next_aw_idx;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic do_write;
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    do_write = aw_held && w_held && !bvalid;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = awaddr[7:2];
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_idx)
        dltc_pkg::IDX_LINK, dltc_pkg::IDX_DCTERM,
        dltc_pkg::IDX_LEVEL, dltc_pkg::IDX_SENSE:
          next_bresp = dltc_pkg::RESP_OKAY;
        default:
          next_bresp = dltc_pkg::RESP_DECERR;
      endcase
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= '0;
      w_byte <= '0;
      w_lane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= dltc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // software registers
  logic [7:0] dc_termination_control, level_control;
  logic [7:0] next_dcterm, next_level;
  logic link_power_down, next_pdl;
  logic wr_ok;
  always_comb
  begin
    next_dcterm = dc_termination_control;
    next_level = level_control;
    next_pdl = link_power_down;
    wr_ok = do_write && w_lane;
    if (wr_ok && aw_idx == dltc_pkg::IDX_DCTERM)
      next_dcterm = w_byte;
    if (wr_ok && aw_idx == dltc_pkg::IDX_LEVEL)
      next_level = w_byte;
    if (wr_ok && aw_idx == dltc_pkg::IDX_LINK)
      next_pdl = w_byte[dltc_pkg::LNK_PDL];
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dc_termination_control <= dltc_pkg::DCTERM_RST;
      level_control <= dltc_pkg::LEVEL_RST;
      link_power_down <= 1'b1;
    end
    else
    begin
      dc_termination_control <= next_dcterm;
      level_control <= next_level;
      link_power_down <= next_pdl;
    end
  end

  // link bring-up and identity check
  dltc_pkg::dltc_link_type link_state, next_link_state;
  logic [2:0] id_cnt, next_id_cnt;
  always_comb
  begin
    next_link_state = link_state;
    next_id_cnt = id_cnt;
    unique case (link_state)
      dltc_pkg::LINK_DOWN:
      begin
        next_id_cnt = '0;
        if (!link_power_down)
          next_link_state = dltc_pkg::LINK_CHECK;
      end
      dltc_pkg::LINK_CHECK:
        if (tick)
        begin
          next_id_cnt = id_cnt + 1'b1;
          if (id_cnt == ID_LAST)
            next_link_state = flags_s[0] ? dltc_pkg::LINK_UP
                                         : dltc_pkg::LINK_FAIL;
        end
      dltc_pkg::LINK_UP, dltc_pkg::LINK_FAIL:
        next_link_state = link_state;
    endcase
    if (link_power_down)
      next_link_state = dltc_pkg::LINK_DOWN;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_state <= dltc_pkg::LINK_DOWN;
      id_cnt <= '0;
    end
    else
    begin
      link_state <= next_link_state;
      id_cnt <= next_id_cnt;
    end
  end

  // line-side controls and sense selection
  logic link_up, hook, boost;
  dltc_pkg::dltc_term_type sel_term;
  logic [4:0] sense_code, next_sense;
  logic dropout, next_dropout;
  dltc_pkg::dltc_fs_type next_fs;
  assign link_up = link_state == dltc_pkg::LINK_UP;
  assign hook = dc_termination_control[dltc_pkg::DCT_HOOK] && link_up;
  assign boost = level_control[dltc_pkg::LVL_FULL];
  assign sel_term = dltc_pkg::dltc_term_type'(
    dc_termination_control[dltc_pkg::DCT_SEL +: 2]);
  assign sif.sample_tick = tick;
  assign sif.hook_active = hook;
  always_comb
  begin
    next_sense = dltc_pkg::CODE_NONE;
    next_dropout = 1'b0;
    if (hook)
    begin
      next_sense = cur_s;
      next_dropout = flags_s[1];
    end
    else if (link_up && dc_termination_control[dltc_pkg::DCT_MON])
      next_sense = mon_s;
    else if (link_up && level_control[dltc_pkg::LVL_MODE])
      next_sense = volt_s;
    unique case (sel_term)
      dltc_pkg::TERM_FCC, dltc_pkg::TERM_CTR21:
        next_fs = dltc_pkg::FS_M1;
      dltc_pkg::TERM_JAPAN:
        next_fs = dltc_pkg::FS_M2_71;
      dltc_pkg::TERM_LV:
        next_fs = dltc_pkg::FS_M5;
    endcase
    if (boost)
      next_fs = dltc_pkg::FS_P3_2;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sense_code <= dltc_pkg::CODE_NONE;
      dropout <= 1'b0;
      link_enable <= 1'b0;
      hookswitch_on <= 1'b0;
      dc_term_mode <= dltc_pkg::TERM_FCC;
      current_limit_on <= 1'b0;
      parallel_imped_on <= 1'b0;
      reduced_voltage_on <= 1'b0;
      full_scale_code <= dltc_pkg::FS_M1;
      line_data_valid <= 1'b0;
    end
    else
    begin
      sense_code <= next_sense;
      dropout <= next_dropout;
      link_enable <= link_up;
      hookswitch_on <= hook;
      dc_term_mode <= sel_term;
      current_limit_on <= sel_term == dltc_pkg::TERM_CTR21
        && dc_termination_control[dltc_pkg::DCT_LIM];
      parallel_imped_on <= dc_termination_control[dltc_pkg::DCT_PAR];
      reduced_voltage_on <= level_control[dltc_pkg::LVL_VOL];
      full_scale_code <= next_fs;
      line_data_valid <= sif.data_valid;
    end
  end

  // AXI read channel
  logic next_rvalid, next_arready;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] status;
  always_comb
  begin
    status = {sense_code == dltc_pkg::CODE_OVL, sif.data_valid,
      dropout, sense_code};
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = dltc_pkg::RESP_OKAY;
      next_rdata = '0;
      unique case (araddr[7:2])
        dltc_pkg::IDX_LINK:
          next_rdata[2:0] = {link_state == dltc_pkg::LINK_FAIL, link_up,
            link_power_down};
        dltc_pkg::IDX_DCTERM:
          next_rdata[7:0] = dc_termination_control;
        dltc_pkg::IDX_LEVEL:
          next_rdata[7:0] = level_control;
        dltc_pkg::IDX_SENSE:
          next_rdata[7:0] = status;
        default:
          next_rresp = dltc_pkg::RESP_DECERR;
      endcase
    end
    next_arready = !next_rvalid;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= '0;
      rresp <= dltc_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      arready <= next_arready;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_link_gate;
    link_state != dltc_pkg::LINK_UP |=> !hookswitch_on && !link_enable;
  endproperty
  a_link_gate: assert property (p_link_gate)
    else $error("line side active while link not up");
  property p_id_fail;
    link_state == dltc_pkg::LINK_CHECK && tick && id_cnt == ID_LAST
      && !flags_s[0] |=> link_state == dltc_pkg::LINK_FAIL ##1 !link_enable;
  endproperty
  a_id_fail: assert property (p_id_fail)
    else $error("identity failure did not refuse the link");
  property p_boost;
    boost |=> full_scale_code == dltc_pkg::FS_P3_2;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost bit did not raise full scale");
  property p_offhook_code;
    hook |=> sense_code == $past(cur_s);
  endproperty
  a_offhook_code: assert property (p_offhook_code)
    else $error("off-hook sense code is not loop current");
  property p_onhook_volt;
    link_up && !dc_termination_control[dltc_pkg::DCT_HOOK]
      && !dc_termination_control[dltc_pkg::DCT_MON]
      && level_control[dltc_pkg::LVL_MODE] |=> sense_code == $past(volt_s);
  endproperty
  a_onhook_volt: assert property (p_onhook_volt)
    else $error("on-hook sense code is not line voltage");
  property p_reset_fcc;
    $rose(aresetn) |-> dc_term_mode == dltc_pkg::TERM_FCC;
  endproperty
  a_reset_fcc: assert property (p_reset_fcc)
    else $error("termination mode after reset is not FCC");
  property p_limit;
    current_limit_on |-> dc_term_mode == dltc_pkg::TERM_CTR21;
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limit outside CTR21 mode");
  property p_bresp_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before acceptance");
endmodule : dltc_top

/* verification/dltc_line_model.sv */
/*
  behavioural line-side model for the termination control bench.
  assumes the bench sets the line conditions and the codes at clock edges.
*/
`timescale 1ns/1ps
module dltc_line_model (
  input wire logic hookswitch_on,
  input wire logic [4:0] set_voltage,
  input wire logic [4:0] set_current,
  input wire logic [4:0] set_monitor,
  input wire logic set_dropout,
  input wire logic set_id_ok,
  output logic [4:0] line_voltage_in,
  output logic [4:0] loop_current_in,
  output logic [4:0] monitor_in,
  output logic line_dropout_in,
  output logic line_id_match_in
);
  assign line_voltage_in = set_voltage;
  // no loop current flows unless the hookswitch conducts
  assign loop_current_in = hookswitch_on ? set_current : 5'h00;
  assign monitor_in = set_monitor;
  assign line_dropout_in = hookswitch_on & set_dropout;
  assign line_id_match_in = set_id_ok;
endmodule : dltc_line_model

/* verification/tb_top.sv */
/*
  register-level bench for the line-state termination control block.
  assumes the line-side model and short sample and settle counts.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 4;
  localparam int SET = 8;
  localparam logic [7:0] A_LNK = {dltc_pkg::IDX_LINK, 2'b00};
  localparam logic [7:0] A_DCT = {dltc_pkg::IDX_DCTERM, 2'b00};
  localparam logic [7:0] A_LVL = {dltc_pkg::IDX_LEVEL, 2'b00};
  localparam logic [7:0] A_SNS = {dltc_pkg::IDX_SENSE, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [4:0] vin, cin, min;
  logic line_dropout_flag, idm, link_enable, hookswitch_on, current_limit_on;
  logic parallel_imped_on, reduced_voltage_on, line_data_valid;
  dltc_pkg::dltc_term_type dc_term_mode;
  dltc_pkg::dltc_fs_type full_scale_code;
  logic [4:0] s_v = 5'h00, s_c = 5'h00, s_m = 5'h00;
  logic s_d = 1'b0, s_id = 1'b0;
  int errors = 0;
  int check_count = 0;
  int n;
  logic [2:0] fs_exp [4] = '{3'h3, 3'h2, 3'h0, 3'h0};
  logic [4:0] cc [3] = '{5'h00, 5'h1f, 5'h01};
  logic dd [3] = '{1'b1, 1'b0, 1'b0};
  logic [31:0] ee [3] = '{32'h60, 32'hdf, 32'h41};
  logic [4:0] lv_code [3] = '{5'h02, 5'h04, 5'h07};
  logic [1:0] lv_mode [3] = '{2'h0, 2'h1, 2'h2};
  logic lv_vol [3] = '{1'b1, 1'b1, 1'b0};

  dltc_top #(.SAMPLE_DIV(DIV), .SETTLE(SET)) dltc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .line_voltage_in(vin), .loop_current_in(cin), .monitor_in(min),
    .line_dropout_in(line_dropout_flag), .line_id_match_in(idm),
    .link_enable(link_enable), .hookswitch_on(hookswitch_on),
    .dc_term_mode(dc_term_mode), .current_limit_on(current_limit_on),
    .parallel_imped_on(parallel_imped_on),
    .reduced_voltage_on(reduced_voltage_on),
    .full_scale_code(full_scale_code), .line_data_valid(line_data_valid));

  dltc_line_model dltc_line_model_inst (
    .hookswitch_on(hookswitch_on), .set_voltage(s_v), .set_current(s_c),
    .set_monitor(s_m), .set_dropout(s_d), .set_id_ok(s_id),
    .line_voltage_in(vin), .loop_current_in(cin), .monitor_in(min),
    .line_dropout_in(line_dropout_flag), .line_id_match_in(idm));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int i;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 100)
    begin
      errors++;
      wrap_up();
    end
    // one idle edge so the next request never lands in the same step
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 100)
    begin
      errors++;
      wrap_up();
    end
    @(posedge aclk);
  endtask : rdr

  initial
  begin
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    rdr(A_DCT);
    chk(rd, 32'h08);
    rdr(A_LVL);
    chk(rd, 32'h00);
    rdr(A_LNK);
    chk(rd, 32'h01);
    chk(32'(dc_term_mode), 32'h2);
    chk(32'(full_scale_code), 32'h0);
    chk(32'(link_enable), 32'h0);
    rdr(8'hfc);
    chk(32'(rs), 32'(dltc_pkg::RESP_DECERR));
    chk(rd, 32'h0);
    wr(8'hfc, 8'hff, 4'h1);
    chk(32'(rs), 32'(dltc_pkg::RESP_DECERR));
    wr(A_DCT, 8'h09, 4'h1);
    cyc(4);
    chk(32'(hookswitch_on), 32'h0);
    wr(A_DCT, 8'h08, 4'h1);
    // line side needs its clock locked before the link comes up
    cyc(20);
    wr(A_LNK, 8'h00, 4'h1);
    cyc(60);
    rdr(A_LNK);
    chk(rd, 32'h04);
    chk(32'(link_enable), 32'h0);
    wr(A_LNK, 8'h01, 4'h1);
    s_id <= 1'b1;
    cyc(6);
    wr(A_LNK, 8'h00, 4'h1);
    for (n = 0; n < 100 && link_enable !== 1'b1; n++)
      @(posedge aclk);
    if (n == 100)
    begin
      errors++;
      wrap_up();
    end
    rdr(A_LNK);
    chk(rd, 32'h02);
    for (int m = 0; m < 4; m++)
    begin
      wr(A_DCT, {2'b00, m[0], 1'b1, m[1:0], 2'b00}, 4'h1);
      cyc(2);
      chk(32'(dc_term_mode), 32'(m));
      chk(32'(current_limit_on), 32'(m == 3));
      chk(32'(parallel_imped_on), 32'(m[0]));
      chk(32'(full_scale_code), 32'(fs_exp[m]));
    end
    wr(A_DCT, 8'h08, 4'h1);
    wr(A_LVL, 8'h03, 4'h1);
    cyc(2);
    chk(32'(full_scale_code), 32'h1);
    chk(32'(reduced_voltage_on), 32'h1);
    wr(A_LVL, 8'h04, 4'h1);
    s_v <= 5'h0d;
    s_m <= 5'h16;
    cyc(8);
    rdr(A_SNS);
    chk(rd, 32'h0d);
    wr(A_DCT, 8'h0a, 4'h1);
    cyc(3);
    rdr(A_SNS);
    chk(rd, 32'h16);
    wr(A_DCT, 8'h09, 4'h0);
    cyc(3);
    chk(32'(hookswitch_on), 32'h0);
    wr(A_SNS, 8'hff, 4'h1);
    chk(32'(rs), 32'(dltc_pkg::RESP_OKAY));
    rdr(A_SNS);
    chk(rd, 32'h16);
    s_c <= 5'h04;
    wr(A_DCT, 8'h0d, 4'h1);
    chk(32'(hookswitch_on), 32'h1);
    for (n = 0; n < 100 && line_data_valid !== 1'b1; n++)
      @(posedge aclk);
    if (n == 100)
    begin
      errors++;
      wrap_up();
    end
    chk(32'(n >= (SET - 1) * DIV - 4 && n <= SET * DIV + 4), 32'h1);
    cyc(6);
    rdr(A_SNS);
    chk(rd, 32'h44);
    // low current in the limited mode: host falls back to the default
    if (rd[4:0] < 5'd6)
      wr(A_DCT, 8'h09, 4'h1);
    cyc(2);
    chk(32'(dc_term_mode), 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      s_c <= cc[i];
      s_d <= dd[i];
      cyc(8);
      rdr(A_SNS);
      chk(rd, ee[i]);
    end
    // seize in the low-current mode, hold in FCC after a scaled delay
    wr(A_DCT, 8'h04, 4'h1);
    wr(A_DCT, 8'h05, 4'h1);
    cyc(40);
    wr(A_DCT, 8'h09, 4'h1);
    cyc(2);
    chk(32'(dc_term_mode), 32'h2);
    chk(32'(hookswitch_on), 32'h1);
    chk(32'(line_data_valid), 32'h1);
    wr(A_DCT, 8'h00, 4'h1);
    // low-voltage start, then the mode picked from the measured current
    for (int i = 0; i < 3; i++)
    begin
      s_c <= lv_code[i];
      wr(A_LVL, 8'h02, 4'h1);
      wr(A_DCT, 8'h01, 4'h1);
      cyc(8);
      rdr(A_SNS);
      chk(32'(rd[4:0]), 32'(lv_code[i]));
      if (rd[4:0] >= 5'd6)
      begin
        wr(A_DCT, 8'h09, 4'h1);
        wr(A_LVL, 8'h00, 4'h1);
      end
      else if (rd[4:0] > 5'd2)
        wr(A_DCT, 8'h05, 4'h1);
      cyc(2);
      chk(32'(dc_term_mode), 32'(lv_mode[i]));
      chk(32'(reduced_voltage_on), 32'(lv_vol[i]));
      wr(A_DCT, 8'h00, 4'h1);
    end
    wr(A_DCT, 8'h08, 4'h1);
    cyc(4);
    chk(32'(line_data_valid), 32'h0);
    chk(32'(hookswitch_on), 32'h0);
    wrap_up();
  end

  initial
  begin
    cyc(20000);
    errors++;
    wrap_up();
  end
endmodule : tb_top
